// ### rtl/txc_pkg.sv
package txc_pkg;
   // ----------------------------------------------------------------
   // register offsets (16-bit cpu port, byte addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] TX_ENGINE_CONTROL_OFS = 16'h2000;
   localparam logic [15:0] TX_ENGINE_STATUS_OFS  = 16'h2002;
   localparam logic [15:0] FIFO_WRITE_PTR_OFS    = 16'h2052;
   localparam logic [15:0] FIFO_READ_PTR_OFS     = 16'h2054;

   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int SCHED_A_ENABLE_BIT          = 0;
   localparam int SCHED_B_ENABLE_BIT          = 1;
   localparam int SCHED_C_ENABLE_BIT          = 2;
   localparam int TX_FIFO_ENABLE_BIT          = 3;
   localparam int IDLE_AUTO_SEND_BIT          = 4;
   localparam int FIFO_OVERRUN_IRQ_ENABLE_BIT = 5;
   localparam int SCHED_ERROR_IRQ_ENABLE_BIT  = 6;
   localparam int READ_POINTER_STEP_BIT       = 7;
   localparam int FORCE_STATUS_EVENTS_BIT     = 8;
   localparam int CONTROL_IMPL_MSB            = 8;

   // ----------------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------------
   localparam int FIFO_OVERRUN_FLAG_BIT  = 5;
   localparam int SCHED_ERROR_FLAG_BIT   = 6;
   localparam int TX_STATUS_SERVICE_BIT  = 15;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int PTR_W = 8;
   localparam logic [15:0]      CONTROL_RESET = 16'h0000;
   localparam logic [PTR_W-1:0] PTR_RESET     = 8'h00;
endpackage

// ### rtl/txc_ptr_if.sv
`timescale 1ns/1ps
interface txc_ptr_if;
   import txc_pkg::*;
   logic             hold;
   logic             advance;
   logic [PTR_W-1:0] ptr;

   modport ctrl (output hold, output advance, input ptr);
   modport ptrm (input hold, input advance, output ptr);
endinterface

// ### rtl/txc_read_ptr.sv
`timescale 1ns/1ps
module txc_read_ptr
   import txc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   txc_ptr_if.ptrm  pif
);
   logic [PTR_W-1:0] ptr_r;

   // ----------------------------------------------------------------
   // read pointer: held at zero while fifo disabled
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_r <= PTR_RESET;
      end else if (pif.hold) begin
         ptr_r <= PTR_RESET; // see R4
      end else if (pif.advance) begin
         ptr_r <= ptr_r + 8'h01; // see R8
      end
   end

   assign pif.ptr = ptr_r;
endmodule

// ### rtl/txc_top.sv
// Operation
// R1: bits 0-2 enable schedulers A, B, C
// R2: host configures scheduler before enabling it
// R3: host reinitializes events after scheduler reconfiguration
// R4: fifo enable low holds read pointer zero
// R5: auto-data sends fifo cells when engine idle
// R6: overrun enable routes overrun flag to service
// R7: error enable routes scheduler error to service
// R8: writing bit 7 steps read pointer
// R9: test bit forces all status events
// R10: control bits 15:9 read as zero
// R11: control register resets to 0000h
// R12: overrun latched when write equals read; w1c
// R13: scheduler error latched on overload; w1c
// R14: status bit 15 set when any flag
// R15: reserved control writes have no effect
`timescale 1ns/1ps
module txc_top
   import txc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [15:0]      cpuAddr,
   input  wire logic [15:0]      cpuWrData,
   input  wire logic             cpuWrEn,
   input  wire logic             cpuRdEn,
   output logic      [15:0]      cpuRdData,
   input  wire logic             engineIdle,
   input  wire logic             cellTaken,
   input  wire logic             schedOverload,
   output logic      [2:0]       schedEnable,
   output logic                  autoSendReq,
   output logic                  serviceRequest,
   output logic      [PTR_W-1:0] fifoReadPointer,
   output logic      [PTR_W-1:0] fifoWritePointer
);
   logic [CONTROL_IMPL_MSB:0] control_r;
   logic                      overrunFlag_r;
   logic                      schedErrFlag_r;
   logic [PTR_W-1:0]          wrPtr_r;
   logic [15:0]               rdData_r;
   logic                      ctrlWrite;
   logic                      statWrite;
   logic                      wpWrite;
   logic                      fifoEnabled;
   logic                      fifoNotEmpty;
   logic                      stepPulse;
   logic                      forceEvents;
   logic                      overrunEvent;
   logic                      schedErrEvent;
   logic [15:0]               statusWord;
   logic [15:0]               controlWord;

   txc_ptr_if pif ();

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign ctrlWrite = cpuWrEn && (cpuAddr == TX_ENGINE_CONTROL_OFS);
   assign statWrite = cpuWrEn && (cpuAddr == TX_ENGINE_STATUS_OFS);
   assign wpWrite   = cpuWrEn && (cpuAddr == FIFO_WRITE_PTR_OFS);

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control_r <= CONTROL_RESET[CONTROL_IMPL_MSB:0]; // see R11
      end else if (ctrlWrite) begin
         // only implemented bits stored, upper bits dropped
         control_r <= cpuWrData[CONTROL_IMPL_MSB:0]; // see R15
      end
   end

   // step bit is a write strobe, never held
   assign stepPulse   = ctrlWrite && cpuWrData[READ_POINTER_STEP_BIT]; // see R8
   assign forceEvents = control_r[FORCE_STATUS_EVENTS_BIT];
   assign fifoEnabled = control_r[TX_FIFO_ENABLE_BIT];

   // ----------------------------------------------------------------
   // scheduler enables
   // ----------------------------------------------------------------
   assign schedEnable = {control_r[SCHED_C_ENABLE_BIT],
                         control_r[SCHED_B_ENABLE_BIT],
                         control_r[SCHED_A_ENABLE_BIT]}; // see R1

   // ----------------------------------------------------------------
   // fifo write pointer and read pointer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= PTR_RESET;
      end else if (wpWrite) begin
         wrPtr_r <= cpuWrData[PTR_W-1:0];
      end
   end

   // a write that clears the enable zeroes the pointer at the same edge
   assign pif.hold    = !fifoEnabled
                        || (ctrlWrite && !cpuWrData[TX_FIFO_ENABLE_BIT]); // see R4
   assign pif.advance = stepPulse || (cellTaken && fifoEnabled); // see R8

   txc_read_ptr i_txc_read_ptr (
      .clk   (clk),
      .rst_n (rst_n),
      .pif   (pif)
   );

   assign fifoReadPointer  = pif.ptr;
   assign fifoWritePointer = wrPtr_r;
   assign fifoNotEmpty     = (wrPtr_r != pif.ptr);

   // ----------------------------------------------------------------
   // idle auto-send of non-cbr cells
   // ----------------------------------------------------------------
   assign autoSendReq = control_r[IDLE_AUTO_SEND_BIT] && fifoEnabled
                        && engineIdle && fifoNotEmpty; // see R5

   // ----------------------------------------------------------------
   // status flags, set wins over write-one-clear
   // ----------------------------------------------------------------
   assign overrunEvent  = forceEvents
                          || (wpWrite && (cpuWrData[PTR_W-1:0] == pif.ptr)); // see R9
   assign schedErrEvent = forceEvents || schedOverload; // see R9

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         overrunFlag_r <= 1'b0;
      end else if (overrunEvent) begin
         overrunFlag_r <= 1'b1; // see R12
      end else if (statWrite && cpuWrData[FIFO_OVERRUN_FLAG_BIT]) begin
         overrunFlag_r <= 1'b0; // see R12
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         schedErrFlag_r <= 1'b0;
      end else if (schedErrEvent) begin
         schedErrFlag_r <= 1'b1; // see R13
      end else if (statWrite && cpuWrData[SCHED_ERROR_FLAG_BIT]) begin
         schedErrFlag_r <= 1'b0; // see R13
      end
   end

   // ----------------------------------------------------------------
   // service request toward main status register
   // ----------------------------------------------------------------
   assign serviceRequest =
      (overrunFlag_r && control_r[FIFO_OVERRUN_IRQ_ENABLE_BIT])    // see R6
      || (schedErrFlag_r && control_r[SCHED_ERROR_IRQ_ENABLE_BIT]); // see R7

   // ----------------------------------------------------------------
   // read-back words
   // ----------------------------------------------------------------
   always_comb begin
      controlWord = 16'h0000; // see R10
      controlWord[CONTROL_IMPL_MSB:0] = control_r;
      controlWord[READ_POINTER_STEP_BIT] = 1'b0;
   end

   always_comb begin
      statusWord = 16'h0000;
      statusWord[FIFO_OVERRUN_FLAG_BIT] = overrunFlag_r;
      statusWord[SCHED_ERROR_FLAG_BIT]  = schedErrFlag_r;
      statusWord[TX_STATUS_SERVICE_BIT] = overrunFlag_r || schedErrFlag_r; // see R14
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_r <= 16'h0000;
      end else if (cpuRdEn) begin
         unique case (cpuAddr)
            TX_ENGINE_CONTROL_OFS: rdData_r <= controlWord;
            TX_ENGINE_STATUS_OFS:  rdData_r <= statusWord;
            FIFO_WRITE_PTR_OFS:    rdData_r <= {8'h00, wrPtr_r};
            FIFO_READ_PTR_OFS:     rdData_r <= {8'h00, pif.ptr};
            default:               rdData_r <= 16'h0000;
         endcase
      end
   end

   assign cpuRdData = rdData_r;
endmodule

// ### bench/txc_top_chk.sv
`timescale 1ns/1ps
module txc_top_chk
   import txc_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic [15:0]      cpuAddr,
   input wire logic [15:0]      cpuWrData,
   input wire logic             cpuWrEn,
   input wire logic             cpuRdEn,
   input wire logic [15:0]      cpuRdData,
   input wire logic             engineIdle,
   input wire logic             cellTaken,
   input wire logic             schedOverload,
   input wire logic [2:0]       schedEnable,
   input wire logic             autoSendReq,
   input wire logic             serviceRequest,
   input wire logic [PTR_W-1:0] fifoReadPointer,
   input wire logic [PTR_W-1:0] fifoWritePointer
);
   wire logic        wc = cpuWrEn && cpuAddr == TX_ENGINE_CONTROL_OFS;
   wire logic [15:0] d  = cpuWrData;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_reset_clear: assert property ($rose(rst_n) |-> schedEnable == 3'h0 && !autoSendReq)
      else $error("state not clear after reset");
   a_sched_follow: assert property (wc |=> schedEnable == $past(d[2:0]))
      else $error("scheduler enables wrong");
   a_ptr_hold: assert property (wc && !d[3] |=> fifoReadPointer == 8'h00)
      else $error("read pointer not held");
   a_step_one: assert property ((wc && d[3] && !d[7]) ##1 !wc ##1
      (wc && d[3] && d[7] && !cellTaken)
      |=> fifoReadPointer == $past(fifoReadPointer) + 8'h01)
      else $error("step wrong");
   a_auto_off: assert property (wc && !d[4] |=> !autoSendReq)
      else $error("auto send while off");
   a_irq_off: assert property (wc && d[6:5] == 2'h0 |=> !serviceRequest)
      else $error("service while masked");
   a_ovr_svc: assert property ((wc && d[5]) ##1 !wc ##1
      (cpuWrEn && cpuAddr == FIFO_WRITE_PTR_OFS && d[7:0] == fifoReadPointer)
      |=> serviceRequest) else $error("overrun lost");
   a_err_svc: assert property ((wc && d[6]) ##1 !wc ##1
      (schedOverload && !cpuWrEn) ##1 !cpuWrEn
      |-> serviceRequest [*2]) else $error("sched error lost");
   a_ctrl_rsvd: assert property (cpuRdEn && cpuAddr == TX_ENGINE_CONTROL_OFS
      |=> cpuRdData[15:7] == 9'h000) else $error("control high bits nonzero");
   a_serv_bit: assert property (cpuRdEn && cpuAddr == TX_ENGINE_STATUS_OFS
      |=> cpuRdData[15] == |cpuRdData[6:5]) else $error("service bit wrong");
endmodule
bind txc_top txc_top_chk i_txc_top_chk (.clk, .rst_n, .cpuAddr, .cpuWrData, .cpuWrEn, .cpuRdEn,
   .cpuRdData, .engineIdle, .cellTaken, .schedOverload, .schedEnable, .autoSendReq,
   .serviceRequest, .fifoReadPointer, .fifoWritePointer);

// ### bench/txc_top_bench.sv
`timescale 1ns/1ps
module txc_top_bench import txc_pkg::*; ;
   localparam logic [15:0] CT = TX_ENGINE_CONTROL_OFS;
   localparam logic [15:0] ST = TX_ENGINE_STATUS_OFS;
   localparam logic [15:0] WP = FIFO_WRITE_PTR_OFS;
   localparam logic [15:0] RP = FIFO_READ_PTR_OFS;
   logic        clk, rst_n, cpuWrEn, cpuRdEn, engineIdle, cellTaken, schedOverload;
   logic        autoSendReq, serviceRequest;
   logic [15:0] cpuAddr, cpuWrData, cpuRdData, rdv;
   logic [2:0]  schedEnable;
   logic [7:0]  fifoReadPointer, fifoWritePointer;
   int          num_errors = 0, checks = 0, cyc = 0;
   txc_top i_txc_top (.clk, .rst_n, .cpuAddr, .cpuWrData, .cpuWrEn, .cpuRdEn, .cpuRdData,
      .engineIdle, .cellTaken, .schedOverload, .schedEnable, .autoSendReq, .serviceRequest,
      .fifoReadPointer, .fifoWritePointer);
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] v);
      @(negedge clk);
      cpuAddr = a;
      cpuWrData = v;
      cpuWrEn = 1'b1;
      @(negedge clk);
      cpuWrEn = 1'b0;
   endtask
   task automatic rd(logic [15:0] a, logic [15:0] e, string n);
      @(negedge clk);
      cpuAddr = a;
      cpuRdEn = 1'b1;
      @(negedge clk);
      cpuRdEn = 1'b0;
      chk(n, e, cpuRdData);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rd(CT, 16'h0000, "ctrl reset");
      rd(ST, 16'h0000, "status reset");
      for (int i = 0; i < 3; i++) begin
         wr(CT, 16'h0001 << i);
         chk("sched", 16'h0001 << i, {13'h0, schedEnable});
      end
      wr(CT, 16'hfe7f);
      rd(CT, 16'h007f, "ctrl rsvd");
      $display("test regs done");
   endtask
   task automatic t_ptr();
      wr(CT, 16'h0008);
      wr(CT, 16'h0088);
      rd(RP, 16'h0001, "step");
      chk("rp port", 16'h0001, {8'h00, fifoReadPointer});
      rd(CT, 16'h0008, "step reads 0");
      pulse(cellTaken);
      rd(RP, 16'h0002, "cell taken");
      wr(CT, 16'h0000);
      chk("ptr cleared", 16'h0000, {8'h00, fifoReadPointer});
      pulse(cellTaken);
      rd(RP, 16'h0000, "ptr held");
      wr(WP, 16'h0005);
      rd(WP, 16'h0005, "write ptr");
      chk("wp port", 16'h0005, {8'h00, fifoWritePointer});
      engineIdle = 1'b1;
      wr(CT, 16'h0018);
      chk("auto on", 16'h0001, {15'h0, autoSendReq});
      wr(CT, 16'h0008);
      chk("auto off", 16'h0000, {15'h0, autoSendReq});
      engineIdle = 1'b0;
      $display("test ptr done");
   endtask
   task automatic t_flags();
      wr(CT, 16'h0020);
      wr(WP, 16'h0000);
      chk("ovr svc", 16'h0001, {15'h0, serviceRequest});
      rd(ST, 16'h8020, "ovr flag");
      wr(CT, 16'h0040);
      chk("masked", 16'h0000, {15'h0, serviceRequest});
      pulse(schedOverload);
      chk("err svc", 16'h0001, {15'h0, serviceRequest});
      rd(ST, 16'h8060, "err flag");
      wr(ST, 16'h0060);
      rd(ST, 16'h0000, "w1c");
      wr(CT, 16'h0100);
      wr(ST, 16'h0060);
      rd(ST, 16'h8060, "forced");
      wr(CT, 16'h0000);
      wr(ST, 16'h0060);
      rd(ST, 16'h0000, "unforced");
      $display("test flags done");
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      {rst_n, cpuWrEn, cpuRdEn, engineIdle, cellTaken, schedOverload} = 6'h00;
      cpuAddr = 16'h0000;
      cpuWrData = 16'h0000;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_regs();
      t_ptr();
      t_flags();
      final_report();
   end
endmodule
